/* include/vdig_pkg.sv */
/*
 Package for the video digitizer host port: select codes, pointer decode,
 command register field layout and struct carriers.
 Assumes a single 100 MHz ref_clk domain in the design that uses it.
*/
package vdig_pkg;
    // ------------------------------------------------------------
    // Widths and select codes
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int LUT_DEPTH = 256;
    localparam logic [1:0] SEL_POINTER = 2'h0;
    localparam logic [1:0] SEL_LUT = 2'h1;
    localparam logic [1:0] SEL_CONTROL = 2'h2;
    localparam logic [1:0] SEL_RESERVED = 2'h3;
    // Register offsets (low two pointer bits under SEL_CONTROL)
    localparam logic [1:0] OFF_COMMAND = 2'h0;
    localparam logic [1:0] OFF_TOP_DAC = 2'h1;
    localparam logic [1:0] OFF_BOTTOM_DAC = 2'h2;
    // ------------------------------------------------------------
    // Command register fields
    // ------------------------------------------------------------
    localparam int CMD_VIDEO_HI = 7;
    localparam int CMD_VIDEO_LO = 6;
    localparam int CMD_SYNC_HI = 5;
    localparam int CMD_SYNC_LO = 4;
    localparam int CMD_SLICE_HI = 3;
    localparam int CMD_SLICE_LO = 2;
    localparam logic [1:0] CMD_RSVD_VALUE = 2'h0;
    localparam int DAC_USED_LO = 2;
    localparam logic [7:0] POINTER_STEP = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [1:0] SLICE_50MV = 2'h0;
    localparam logic [1:0] SLICE_75MV = 2'h1;
    localparam logic [1:0] SLICE_100MV = 2'h2;
    localparam logic [1:0] SLICE_125MV = 2'h3;

    // Analog control outputs as one carrier
    typedef struct packed {
        logic [1:0] video_select;
        logic [1:0] sync_select;
        logic [1:0] slice_level;
        logic [5:0] top_dac;
        logic [5:0] bottom_dac;
    } analog_ctrl_t;

    // Host strobes and selects as one carrier
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic sel_high;
        logic sel_low;
    } host_strobe_t;
endpackage : vdig_pkg

/* verilog/video_digitizer_host_port.sv */
/*
 Host port and pixel lookup path of a single-channel 8-bit video digitizer:
 pointer, command and reference code registers, lookup RAM and the pixel
 output stage with its clocked three-state control.
 Assumes host strobes, selects and write data are asynchronous pins that are
 synchronised here, that the converter code arrives in the ref_clk domain,
 and that the surrounding logic resolves the pixel bus and the host data bus
 from the enables. Host strobes must last at least three clocks low and three
 clocks high so that the synchronisers see every edge.
*/
`timescale 1ns/1ps
module video_digitizer_host_port (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic reset_n, // Async reset, active low
    input wire logic host_rd_n, // Host read strobe, async
    input wire logic host_wr_n, // Host write strobe, async
    input wire logic host_select_low, // Select line low, async
    input wire logic host_select_high, // Select line high, async
    input wire logic [7:0] host_data_bus_in, // Host write data, async
    output logic [7:0] host_data_bus_out, // Host read data
    output logic host_data_bus_oe, // High while driving host bus
    input wire logic [7:0] converter_code, // Sample code, same domain
    input wire logic output_enable_n, // Pixel enable, async, low active
    output logic [7:0] pixel_output_bus, // Pixel data
    output logic pixel_output_oe, // High while driving pixels
    output vdig_pkg::analog_ctrl_t analog_ctrl // Mux, slicer, DAC codes
);
    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------

    // Strobe carrier: first stage, second stage, one clock older
    vdig_pkg::host_strobe_t strobe_meta_q;
    vdig_pkg::host_strobe_t strobe_q;
    vdig_pkg::host_strobe_t strobe_prev_q;

    // Write data and pixel enable stages
    logic [7:0] wdata_meta_q;
    logic [7:0] wdata_q;
    logic oe_meta_q;
    logic oe_sync_q;

    // Two-flop sync of strobes and selects, older copy for edges
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_meta_q <= '{rd_n: 1'b1, wr_n: 1'b1, sel_high: 1'b0, sel_low: 1'b0};
            strobe_q <= '{rd_n: 1'b1, wr_n: 1'b1, sel_high: 1'b0, sel_low: 1'b0};
            strobe_prev_q <= '{rd_n: 1'b1, wr_n: 1'b1, sel_high: 1'b0, sel_low: 1'b0};
        end else begin
            strobe_meta_q <= '{rd_n: host_rd_n, wr_n: host_wr_n,
                               sel_high: host_select_high, sel_low: host_select_low};
            strobe_q <= strobe_meta_q;
            strobe_prev_q <= strobe_q;
        end
    end

    // Two-flop sync of write data, read only at write end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wdata_meta_q <= vdig_pkg::ZERO_BYTE;
            wdata_q <= vdig_pkg::ZERO_BYTE;
        end else begin
            wdata_meta_q <= host_data_bus_in;
            wdata_q <= wdata_meta_q;
        end
    end

    // Two-flop sync of pixel enable, idle keeps bus floated
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            oe_meta_q <= 1'b1;
            oe_sync_q <= 1'b1;
        end else begin
            oe_meta_q <= output_enable_n;
            oe_sync_q <= oe_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Host decode
    // ------------------------------------------------------------

    // Pointer and its next value
    logic [7:0] pointer_q;
    logic [7:0] pointer_d;

    // Strobe levels and edges after synchronisation
    logic [1:0] sel_code;
    logic [1:0] prev_sel;
    logic rd_active;
    logic wr_end;
    logic rd_end;
    logic rd_start;

    // Target decode
    logic sel_pointer;
    logic sel_lut;
    logic sel_control;
    logic ctl_command;
    logic ctl_top;
    logic ctl_bottom;
    logic host_on_lut;

    // Low pointer bits pick one of four control places
    function automatic logic offset_hit(input logic [7:0] ptr, input logic [1:0] offset);
        return ptr[1:0] == offset;
    endfunction : offset_hit

    // Writes taken on the synced strobe rise, read byte on its fall
    // Write selects taken one clock earlier, still inside strobe; read selects at the strobe fall
    // Strobes need three clocks low and three high
    // Select code, cycle edges and target decode
    assign sel_code = {strobe_q.sel_high, strobe_q.sel_low};
    assign prev_sel = {strobe_prev_q.sel_high, strobe_prev_q.sel_low};
    assign rd_active = !strobe_q.rd_n;
    assign rd_start = !strobe_q.rd_n && strobe_prev_q.rd_n;
    assign rd_end = strobe_q.rd_n && !strobe_prev_q.rd_n;
    assign wr_end = strobe_q.wr_n && !strobe_prev_q.wr_n;
    assign sel_pointer = (prev_sel == vdig_pkg::SEL_POINTER);
    assign sel_lut = (prev_sel == vdig_pkg::SEL_LUT);
    assign sel_control = (prev_sel == vdig_pkg::SEL_CONTROL);
    assign ctl_command = sel_control && offset_hit(pointer_q, vdig_pkg::OFF_COMMAND);
    assign ctl_top = sel_control && offset_hit(pointer_q, vdig_pkg::OFF_TOP_DAC);
    assign ctl_bottom = sel_control && offset_hit(pointer_q, vdig_pkg::OFF_BOTTOM_DAC);
    assign host_on_lut = (sel_code == vdig_pkg::SEL_LUT) && (rd_active || !strobe_q.wr_n);

    // Pointer update: direct load on pointer write, else modulo-256 step
    always_comb begin
        pointer_d = pointer_q;
        if (wr_end && sel_pointer) begin
            pointer_d = wdata_q;
        end else if (wr_end || rd_end) begin
            pointer_d = pointer_q + vdig_pkg::POINTER_STEP;
        end
    end

    // ------------------------------------------------------------
    // Registers and lookup RAM
    // ------------------------------------------------------------

    // Control registers, no reset value
    logic [7:0] command_q;
    logic [7:0] top_dac_q;
    logic [7:0] bottom_dac_q;

    // Lookup RAM and its single port
    logic [7:0] lut_mem [vdig_pkg::LUT_DEPTH];
    logic [7:0] lut_index;
    logic [7:0] lut_word;

    // Host read data before capture
    logic [7:0] read_value;

    // Pointer register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pointer_q <= vdig_pkg::ZERO_BYTE;
        end else begin
            pointer_q <= pointer_d;
        end
    end

    // Command register, reserved low bits stored as zero
    always_ff @(posedge ref_clk) begin
        if (wr_end && ctl_command) begin
            command_q <= {wdata_q[vdig_pkg::CMD_VIDEO_HI:vdig_pkg::CMD_SLICE_LO], vdig_pkg::CMD_RSVD_VALUE};
        end
    end

    // Top reference code, no reset value
    always_ff @(posedge ref_clk) begin
        if (wr_end && ctl_top) begin
            top_dac_q <= wdata_q;
        end
    end

    // Bottom reference code; reserved writes land nowhere
    always_ff @(posedge ref_clk) begin
        if (wr_end && ctl_bottom) begin
            bottom_dac_q <= wdata_q;
        end
    end

    // Pixel data undefined while host is on the lookup
    // Host should keep off the lookup while digitizing
    // Single-port lookup: host pointer wins over pixel index
    assign lut_index = host_on_lut ? pointer_q : converter_code;
    assign lut_word = lut_mem[lut_index];

    // Lookup RAM write, no reset
    always_ff @(posedge ref_clk) begin
        if (wr_end && sel_lut) begin
            lut_mem[pointer_q] <= wdata_q;
        end
    end

    // Reserved offset and reserved select both read zero
    // Read data mux; reserved locations read zero
    always_comb begin
        read_value = vdig_pkg::ZERO_BYTE;
        unique case (sel_code)
            vdig_pkg::SEL_POINTER: read_value = pointer_q;
            vdig_pkg::SEL_LUT: read_value = lut_mem[pointer_q];
            vdig_pkg::SEL_CONTROL: begin
                unique case (pointer_q[1:0])
                    vdig_pkg::OFF_COMMAND: read_value = command_q;
                    vdig_pkg::OFF_TOP_DAC: read_value = top_dac_q;
                    vdig_pkg::OFF_BOTTOM_DAC: read_value = bottom_dac_q;
                    vdig_pkg::SEL_RESERVED: read_value = vdig_pkg::ZERO_BYTE;
                endcase
            end
            vdig_pkg::SEL_RESERVED: read_value = vdig_pkg::ZERO_BYTE;
        endcase
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Host read data latched at read start, held through strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            host_data_bus_out <= vdig_pkg::ZERO_BYTE;
        end else if (rd_start) begin
            host_data_bus_out <= read_value;
        end
    end

    // Host bus driven while the synced read strobe is low
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            host_data_bus_oe <= 1'b0;
        end else begin
            host_data_bus_oe <= rd_active;
        end
    end

    // ------------------------------------------------------------
    // Pixel outputs
    // ------------------------------------------------------------

    // Pixel path from the lookup word
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pixel_output_bus <= vdig_pkg::ZERO_BYTE;
        end else begin
            pixel_output_bus <= lut_word;
        end
    end

    // Clocked three-state control of the pixel bus
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pixel_output_oe <= 1'b0;
        end else begin
            pixel_output_oe <= !oe_sync_q;
        end
    end

    // ------------------------------------------------------------
    // Analog control outputs
    // ------------------------------------------------------------

    // Two-bit command field from its low bit position
    function automatic logic [1:0] cmd_field(input logic [7:0] code, input int lo);
        return code[lo+:2];
    endfunction : cmd_field

    // Upper six bits of a reference code; low two unused
    function automatic logic [5:0] dac_field(input logic [7:0] code);
        return code[vdig_pkg::DATA_W-1:vdig_pkg::DAC_USED_LO];
    endfunction : dac_field

    // Analog controls from command and DAC registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            analog_ctrl <= '0;
        end else begin
            analog_ctrl.video_select <= cmd_field(command_q, vdig_pkg::CMD_VIDEO_LO);
            analog_ctrl.sync_select <= cmd_field(command_q, vdig_pkg::CMD_SYNC_LO);
            analog_ctrl.slice_level <= cmd_field(command_q, vdig_pkg::CMD_SLICE_LO);
            analog_ctrl.top_dac <= dac_field(top_dac_q);
            analog_ctrl.bottom_dac <= dac_field(bottom_dac_q);
        end
    end
endmodule : video_digitizer_host_port

/* tb/host_port_sva.sv */
/* Checker for host port strobe, read drive and pixel enable timing.
 Assumes it is bound to the top module, one ref_clk domain. */
`timescale 1ns/1ps
module host_port_sva (
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic host_rd_n, // Read strobe
    input wire logic host_wr_n, // Write strobe
    input wire logic output_enable_n, // Pixel enable
    input wire logic [7:0] host_data_bus_out, // Read byte
    input wire logic host_data_bus_oe, // Read drive
    input wire logic pixel_output_oe, // Pixel drive
    input wire vdig_pkg::analog_ctrl_t analog_ctrl // Controls
);
    // ------
    // Timing properties
    // ------
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    rd_drive_a: assert property (!host_rd_n [*4] |=> host_data_bus_oe)
        else $error("read byte not driven");
    rd_release_a: assert property (host_rd_n [*4] |=> !host_data_bus_oe)
        else $error("read drive kept");
    rd_hold_a: assert property (host_rd_n [*4] |=> $stable(host_data_bus_out))
        else $error("read byte moved");
    drive_cause_a: assert property ($rose(host_data_bus_oe) |-> !$past(host_rd_n, 2))
        else $error("drive without read");
    drive_end_a: assert property ($fell(host_data_bus_oe) |-> $past(host_rd_n, 2))
        else $error("drive dropped early");
    ctrl_hold_a: assert property (host_wr_n [*8] |=> $stable(analog_ctrl))
        else $error("controls moved without write");
    pix_on_a: assert property (!output_enable_n [*4] |=> pixel_output_oe)
        else $error("pixels not driven");
    pix_off_a: assert property (output_enable_n [*4] |=> !pixel_output_oe)
        else $error("pixels not floated");
    pix_step_a: assert property (output_enable_n [*4] ##1 !output_enable_n |=> !pixel_output_oe)
        else $error("pixel enable not clocked");
    // Main scenarios reached
    cover property (!host_rd_n [*4]);
    cover property (!host_wr_n [*4]);
    cover property ($rose(pixel_output_oe));
endmodule : host_port_sva

/* tb/host_far_side.sv */
/* Far side model: host data wire and pixel capture.
 Assumes the bench supplies write byte and strobe. */
`timescale 1ns/1ps
module host_far_side (
    input wire logic ref_clk, // Clock
    input wire logic host_wr_n, // Write strobe
    input wire logic [7:0] drive_data, // Host byte
    input wire logic host_data_bus_oe, // Device drives
    input wire logic [7:0] host_data_bus_out, // Device byte
    input wire logic pixel_output_oe, // Pixel drive
    input wire logic [7:0] pixel_output_bus, // Pixel byte
    output logic [7:0] host_wire, // Resolved host bus
    output logic [7:0] pixel_seen // Resolved pixels
);
    logic [2:0] hold_q = 3'h7;
    logic [7:0] host_last_q = 8'h00;
    logic [7:0] pix_last_q = 8'h00;
    // Host keeps its byte a few clocks past the strobe
    always_ff @(posedge ref_clk) begin
        hold_q <= !host_wr_n ? 3'h0 : (hold_q == 3'h7 ? hold_q : hold_q + 3'h1);
        host_last_q <= host_wire;
        pix_last_q <= pixel_seen;
    end
    // Released lines show the inverse of the last value
    assign host_wire = (!host_wr_n || hold_q < 3'h5) ? drive_data :
        (host_data_bus_oe ? host_data_bus_out : ~host_last_q);
    assign pixel_seen = pixel_output_oe ? pixel_output_bus : ~pix_last_q;
endmodule : host_far_side

/* tb/testbench.sv */
/* Testbench for the host port: registers, lookup table, pixel path.
 Assumes package, design, checker and far side compiled first. */
`timescale 1ns/1ps
module testbench;
    // ------
    // Stimulus and observed signals
    // ------
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic host_rd_n = 1'b1;
    logic host_wr_n = 1'b1;
    logic [1:0] sel = 2'h0;
    logic [7:0] drive_data = 8'h00;
    logic [7:0] converter_code = 8'h00;
    logic output_enable_n = 1'b1;
    logic [7:0] host_wire, host_out, pixel_bus, pixel_seen, r, t;
    logic host_oe, pixel_oe;
    vdig_pkg::analog_ctrl_t ctrl;
    logic [7:0] lut_exp [256];
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'h1d29_0028;
    initial forever #5 ref_clk = ~ref_clk;
    video_digitizer_host_port uut (.ref_clk(ref_clk), .reset_n(reset_n), .host_rd_n(host_rd_n),
        .host_wr_n(host_wr_n), .host_select_low(sel[0]), .host_select_high(sel[1]),
        .host_data_bus_in(host_wire), .host_data_bus_out(host_out), .host_data_bus_oe(host_oe),
        .converter_code(converter_code), .output_enable_n(output_enable_n),
        .pixel_output_bus(pixel_bus), .pixel_output_oe(pixel_oe), .analog_ctrl(ctrl));
    host_far_side far (.ref_clk(ref_clk), .host_wr_n(host_wr_n), .drive_data(drive_data),
        .host_data_bus_oe(host_oe), .host_data_bus_out(host_out), .pixel_output_oe(pixel_oe),
        .pixel_output_bus(pixel_bus), .host_wire(host_wire), .pixel_seen(pixel_seen));
    // ------
    // Compare, transfer and closing tasks
    // ------
    task check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_byte
    task xfer(input logic wr, input logic [1:0] s, input logic [7:0] d, input logic [7:0] exp);
        @(posedge ref_clk);
        sel <= s;
        drive_data <= d;
        if (wr) host_wr_n <= 1'b0;
        else host_rd_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        if (!wr) check_byte(host_out, exp);
        host_wr_n <= 1'b1;
        host_rd_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask : xfer
    task complete_run;
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    // ------
    // Main sequence
    // ------
    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 3; i++) xfer(1, vdig_pkg::SEL_CONTROL, 8'h00, 8'h00);
        xfer(1, vdig_pkg::SEL_POINTER, 8'h00, 8'h00);
        for (int i = 0; i < 256; i++) begin
            lut_exp[i] = 8'($random(seed));
            xfer(1, vdig_pkg::SEL_LUT, lut_exp[i], 8'h00);
        end
        xfer(0, vdig_pkg::SEL_POINTER, 8'h00, 8'h00);
        xfer(1, vdig_pkg::SEL_POINTER, 8'h00, 8'h00);
        for (int i = 0; i < 256; i++) xfer(0, vdig_pkg::SEL_LUT, 8'h00, lut_exp[i]);
        xfer(0, vdig_pkg::SEL_POINTER, 8'h00, 8'h00);
        // Every field code, reserved places, decode of low pointer bits
        for (int i = 0; i < 4; i++) begin
            r = {i[1:0], ~i[1:0], i[1:0], 2'($random(seed))};
            t = {6'($random(seed)), 2'h0};
            xfer(1, vdig_pkg::SEL_POINTER, {6'($random(seed)), 2'h0}, 8'h00);
            xfer(1, vdig_pkg::SEL_CONTROL, r, 8'h00);
            xfer(1, vdig_pkg::SEL_CONTROL, t, 8'h00);
            xfer(1, vdig_pkg::SEL_CONTROL, ~t & 8'hfc, 8'h00);
            xfer(1, vdig_pkg::SEL_CONTROL, 8'hff, 8'h00);
            xfer(1, vdig_pkg::SEL_RESERVED, 8'hff, 8'h00);
            xfer(1, vdig_pkg::SEL_POINTER, 8'hfc, 8'h00);
            xfer(0, vdig_pkg::SEL_CONTROL, 8'h00, {r[7:2], 2'h0});
            xfer(0, vdig_pkg::SEL_CONTROL, 8'h00, t);
            xfer(0, vdig_pkg::SEL_CONTROL, 8'h00, ~t & 8'hfc);
            xfer(0, vdig_pkg::SEL_CONTROL, 8'h00, 8'h00);
            xfer(0, vdig_pkg::SEL_RESERVED, 8'h00, 8'h00);
            xfer(0, vdig_pkg::SEL_POINTER, 8'h00, 8'h01);
            check_byte({ctrl.video_select, ctrl.sync_select, ctrl.slice_level, 2'h0}, {r[7:2], 2'h0});
            check_byte({ctrl.top_dac, ctrl.bottom_dac[1:0]}, {t[7:2], ~t[3:2]});
        end
        // Pixel path through the table, corner codes first
        output_enable_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        t = converter_code;
        for (int i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            r = i == 0 ? 8'h00 : (i == 1 ? 8'hff : 8'($random(seed)));
            converter_code <= r;
            @(negedge ref_clk);
            check_byte(pixel_seen, lut_exp[t]);
            t = r;
        end
        @(posedge ref_clk);
        output_enable_n <= 1'b1;
        @(negedge ref_clk);
        check_byte({7'h00, pixel_oe}, 8'h01);
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        check_byte({7'h00, pixel_oe}, 8'h00);
        complete_run();
    end
endmodule : testbench
bind video_digitizer_host_port host_port_sva chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .output_enable_n(output_enable_n),
    .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
    .pixel_output_oe(pixel_output_oe), .analog_ctrl(analog_ctrl));
